/* src/pllrt_pkg.sv */
// constants for the clock, tick and pseudo-stop control block
package pllrt_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_RATE   = 3'h0;
	localparam logic [2:0] ADDR_CTRL   = 3'h1;
	localparam logic [2:0] ADDR_FLAGS  = 3'h2;
	localparam logic [2:0] ADDR_CLEAR  = 3'h3;
	localparam logic [2:0] ADDR_ENABLE = 3'h4;
	localparam logic [2:0] ADDR_STOP   = 3'h5;

	// ----------------------------------------------------------------
	// control register bits
	// ----------------------------------------------------------------
	localparam int CTRL_AUTO  = 0;
	localparam int CTRL_ACQ   = 1;
	localparam int CTRL_PWR   = 2;
	localparam int CTRL_SEL   = 3;
	localparam int CTRL_CME   = 4;
	localparam int CTRL_SELF_CLOCK_MODE_ENABLE  = 5;

	// ----------------------------------------------------------------
	// flag, clear and enable bits (same layout)
	// ----------------------------------------------------------------
	localparam int EV_TICK    = 0;
	localparam int EV_SETTLE  = 1;
	localparam int EV_SCM     = 2;
	localparam int EV_W       = 3;
	localparam int FL_TRACK   = 4;
	localparam int FL_SETTLED = 5;
	localparam int FL_SCMACT  = 6;
	localparam int FL_STOP    = 7;

	// ----------------------------------------------------------------
	// reset values and widths
	// ----------------------------------------------------------------
	localparam logic [6:0] RATE_RST = 7'h00;
	localparam logic [5:0] CTRL_RST = 6'h03;
	localparam logic [2:0] EN_RST   = 3'h0;
	localparam int PRE_BASE  = 9;
	localparam int TICK_CW   = 21;

	typedef enum logic {
		PLLRT_RUN  = 1'b0,
		PLLRT_STOP = 1'b1
	} pllrt_mode_t;

endpackage : pllrt_pkg

/* src/pllrt_tick_div.sv */
// periodic tick divider on the crystal clock
`timescale 1ns/1ns
module pllrt_tick_div (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// rate selection
	input  wire logic [6:0] tick_rate_select,
	// tick event
	output logic            tick_pulse
);

	// ----------------------------------------------------------------
	// period decode
	// ----------------------------------------------------------------
	function automatic logic [20:0] pllrt_period(input logic [6:0] r);
		logic [20:0] p;
		p = {17'h0_0000, r[3:0]} + 21'h00_0001;
		pllrt_period = p << (5'(pllrt_pkg::PRE_BASE) + {2'b00, r[6:4]});
	endfunction : pllrt_period

	logic [20:0] cnt_reg;
	logic [20:0] cnt_next;
	logic [6:0]  rate_reg;
	logic        tick_next;

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	always_comb begin
		cnt_next  = cnt_reg + 21'h00_0001;
		tick_next = 1'b0;
		// restart on any rate change so an old period never leaks
		if (tick_rate_select[6:4] == 3'b000 ||
		    tick_rate_select != rate_reg) begin
			cnt_next = 21'h00_0000;
		end else if (cnt_reg == pllrt_period(rate_reg) - 21'h00_0001) begin
			cnt_next  = 21'h00_0000;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_reg    <= 21'h00_0000;
			rate_reg   <= pllrt_pkg::RATE_RST;
			tick_pulse <= 1'b0;
		end else begin
			cnt_reg    <= cnt_next;
			rate_reg   <= tick_rate_select;
			tick_pulse <= tick_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_tick_off;
		@(posedge clk_sys) disable iff (rst)
		(tick_rate_select[6:4] == 3'b000) [*2] |-> !tick_pulse;
	endproperty
	a_tick_off: assert property (p_tick_off)
		else $error("tick while rate field is off");

	property p_tick_gap;
		@(posedge clk_sys) disable iff (rst)
		tick_pulse |=> !tick_pulse [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("tick period shorter than minimum");

endmodule : pllrt_tick_div

/* src/pllrt_ctrl.sv */
// clock generator control: tick, loop filter modes, pseudo-stop
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
module pllrt_ctrl (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	// analog detector pins
	input  wire logic       in_lock_tol,
	input  wire logic       out_unlock_tol,
	input  wire logic       in_track_tol,
	input  wire logic       out_untrack_tol,
	input  wire logic       crystal_lost,
	// clock control outputs
	output logic            synth_power_enable,
	output logic            system_clock_from_synth,
	output logic            filter_acquire,
	output logic            self_clock_active,
	output logic            stop_active,
	// reset and interrupt
	output logic            monitor_fail_reset,
	output logic            reset_from_monitor,
	output logic            irq
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pin_s1_reg;
	logic [4:0] pin_s2_reg;
	logic       lost_d_reg;
	logic s_lock, s_unlock, s_trk, s_untrk, s_lost, lost_rise;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_s1_reg <= 5'h00;
			pin_s2_reg <= 5'h00;
			lost_d_reg <= 1'b0;
		end else begin
			pin_s1_reg <= {crystal_lost, out_untrack_tol, in_track_tol,
			               out_unlock_tol, in_lock_tol};
			pin_s2_reg <= pin_s1_reg;
			lost_d_reg <= pin_s2_reg[4];
		end
	end

	assign s_lock    = pin_s2_reg[0];
	assign s_unlock  = pin_s2_reg[1];
	assign s_trk     = pin_s2_reg[2];
	assign s_untrk   = pin_s2_reg[3];
	assign s_lost    = pin_s2_reg[4];
	assign lost_rise = s_lost & ~lost_d_reg;

	// ----------------------------------------------------------------
	// tick divider
	// ----------------------------------------------------------------
	logic [6:0] rate_reg;
	logic [6:0] rate_next;
	logic       tick_pulse;

	pllrt_tick_div u_tick (
		.clk_sys          (clk_sys),
		.rst              (rst),
		.tick_rate_select (rate_reg),
		.tick_pulse       (tick_pulse)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [5:0]             ctrl_reg, ctrl_next;
	logic [2:0]             en_reg, en_next;
	logic [2:0]             flag_reg, flag_next;
	logic                   settled_reg, settled_next;
	logic                   track_reg, track_next;
	logic                   scm_reg, scm_next;
	logic                   mfr_reg, mfr_next;
	logic                   vec_reg, vec_next;
	logic [7:0]             rdata_next;
	pllrt_pkg::pllrt_mode_t mode_reg, mode_next;
	logic [2:0]             ev_set;
	logic                   acq_mode;
	logic                   wake_other;

	// filter mode: detector in auto, software bit in manual
	assign acq_mode = ctrl_reg[pllrt_pkg::CTRL_AUTO] ? ~track_reg
	                : ctrl_reg[pllrt_pkg::CTRL_ACQ];

	assign wake_other = |(flag_reg[1:0] & en_reg[1:0]);

	always_comb begin
		ctrl_next    = ctrl_reg;
		en_next      = en_reg;
		rate_next    = rate_reg;
		mode_next    = mode_reg;
		scm_next     = scm_reg;
		mfr_next     = 1'b0;
		vec_next     = vec_reg;
		settled_next = settled_reg;
		track_next   = track_reg;
		ev_set       = 3'b000;

		// settled flag from lock detector
		if (s_lock) begin
			settled_next = 1'b1;
		end else if (s_unlock) begin
			settled_next = 1'b0;
		end
		ev_set[pllrt_pkg::EV_SETTLE] = settled_next ^ settled_reg;
		ev_set[pllrt_pkg::EV_TICK]   = tick_pulse;

		// tracking flag
		if (ctrl_reg[pllrt_pkg::CTRL_AUTO]) begin
			if (s_trk) begin
				track_next = 1'b1;
			end else if (s_untrk) begin
				track_next = 1'b0;
			end
		end else begin
			track_next = ~ctrl_reg[pllrt_pkg::CTRL_ACQ];
		end

		// register writes
		if (reg_wr) begin
			unique case (reg_addr)
				pllrt_pkg::ADDR_RATE:   rate_next = reg_wdata[6:0];
				pllrt_pkg::ADDR_CTRL:   ctrl_next = reg_wdata[5:0];
				pllrt_pkg::ADDR_ENABLE: en_next   = reg_wdata[2:0];
				pllrt_pkg::ADDR_STOP: begin
					if (reg_wdata[0]) begin
						mode_next = pllrt_pkg::PLLRT_STOP;
					end
				end
				default: ;
			endcase
		end

		// pseudo-stop exits
		if (mode_reg == pllrt_pkg::PLLRT_STOP) begin
			if (lost_rise && ctrl_reg[pllrt_pkg::CTRL_CME] &&
			    !ctrl_reg[pllrt_pkg::CTRL_SELF_CLOCK_MODE_ENABLE]) begin
				mfr_next = 1'b1;
				vec_next = 1'b1;
			end else if (lost_rise && ctrl_reg[pllrt_pkg::CTRL_CME]) begin
				ev_set[pllrt_pkg::EV_SCM] = 1'b1;
				if (en_reg[pllrt_pkg::EV_SCM]) begin
					scm_next  = 1'b1;
					mode_next = pllrt_pkg::PLLRT_RUN;
				end
			end
			if (wake_other) begin
				mode_next = pllrt_pkg::PLLRT_RUN;
			end
			// synth was powered down, so fall back to crystal
			if (mode_next == pllrt_pkg::PLLRT_RUN) begin
				ctrl_next[pllrt_pkg::CTRL_SEL] = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// sticky flags: set wins over clear
	// ----------------------------------------------------------------
	always_comb begin
		flag_next = flag_reg;
		if (reg_wr && reg_addr == pllrt_pkg::ADDR_CLEAR) begin
			flag_next = flag_reg & ~reg_wdata[2:0];
		end
		flag_next = flag_next | ev_set;
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				pllrt_pkg::ADDR_RATE:   rdata_next = {1'b0, rate_reg};
				pllrt_pkg::ADDR_CTRL:   rdata_next = {2'b00, ctrl_reg};
				pllrt_pkg::ADDR_FLAGS:  rdata_next = {mode_reg, scm_reg,
				                         settled_reg, track_reg, 1'b0,
				                         flag_reg};
				pllrt_pkg::ADDR_ENABLE: rdata_next = {5'h00, en_reg};
				default:                rdata_next = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rate_reg    <= pllrt_pkg::RATE_RST;
			ctrl_reg    <= pllrt_pkg::CTRL_RST;
			en_reg      <= pllrt_pkg::EN_RST;
			flag_reg    <= 3'h0;
			settled_reg <= 1'b0;
			track_reg   <= 1'b0;
			scm_reg     <= 1'b0;
			mode_reg    <= pllrt_pkg::PLLRT_RUN;
			mfr_reg     <= 1'b0;
			vec_reg     <= 1'b0;
			reg_rdata   <= 8'h00;
		end else if (mfr_reg) begin
			// monitor fail acts like external reset but keeps vector
			rate_reg    <= pllrt_pkg::RATE_RST;
			ctrl_reg    <= pllrt_pkg::CTRL_RST;
			en_reg      <= pllrt_pkg::EN_RST;
			flag_reg    <= 3'h0;
			settled_reg <= 1'b0;
			track_reg   <= 1'b0;
			scm_reg     <= 1'b0;
			mode_reg    <= pllrt_pkg::PLLRT_RUN;
			mfr_reg     <= 1'b0;
			reg_rdata   <= 8'h00;
		end else begin
			rate_reg    <= rate_next;
			ctrl_reg    <= ctrl_next;
			en_reg      <= en_next;
			flag_reg    <= flag_next;
			settled_reg <= settled_next;
			track_reg   <= track_next;
			scm_reg     <= scm_next;
			mode_reg    <= mode_next;
			mfr_reg     <= mfr_next;
			vec_reg     <= vec_next;
			reg_rdata   <= rdata_next;
		end
	end

	assign synth_power_enable      = ctrl_reg[pllrt_pkg::CTRL_PWR];
	assign system_clock_from_synth = ctrl_reg[pllrt_pkg::CTRL_SEL];
	assign filter_acquire          = acq_mode;
	assign self_clock_active       = scm_reg;
	assign stop_active             = mode_reg;
	assign monitor_fail_reset      = mfr_reg;
	assign reset_from_monitor      = vec_reg;
	assign irq                     = |(flag_reg & en_reg);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_acq_track;
		@(posedge clk_sys) disable iff (rst)
		!ctrl_reg[pllrt_pkg::CTRL_AUTO] && ctrl_reg[pllrt_pkg::CTRL_ACQ]
		|=> !track_reg;
	endproperty
	a_acq_track: assert property (p_acq_track)
		else $error("track set in acquisition");

	property p_auto_trk;
		@(posedge clk_sys) disable iff (rst || mfr_reg)
		ctrl_reg[pllrt_pkg::CTRL_AUTO] && s_trk && !reg_wr
		|=> track_reg && !filter_acquire;
	endproperty
	a_auto_trk: assert property (p_auto_trk)
		else $error("auto mode did not enter tracking");

	property p_settle;
		@(posedge clk_sys) disable iff (rst || mfr_reg)
		s_lock |=> settled_reg;
	endproperty
	a_settle: assert property (p_settle)
		else $error("settled flag not set in lock");

	property p_settle_irq;
		@(posedge clk_sys) disable iff (rst || mfr_reg)
		$changed(settled_reg) && en_reg[pllrt_pkg::EV_SETTLE]
		&& !reg_wr |=> irq;
	endproperty
	a_settle_irq: assert property (p_settle_irq)
		else $error("no irq on settled change");

	property p_mon_rst;
		@(posedge clk_sys) disable iff (rst)
		stop_active && lost_rise && ctrl_reg[pllrt_pkg::CTRL_CME]
		&& !ctrl_reg[pllrt_pkg::CTRL_SELF_CLOCK_MODE_ENABLE]
		|=> monitor_fail_reset ##1 (!stop_active && reset_from_monitor
		&& rate_reg == pllrt_pkg::RATE_RST);
	endproperty
	a_mon_rst: assert property (p_mon_rst)
		else $error("monitor fail reset missing");

	property p_scm_wake;
		@(posedge clk_sys) disable iff (rst || mfr_reg)
		stop_active && lost_rise && ctrl_reg[pllrt_pkg::CTRL_CME]
		&& ctrl_reg[pllrt_pkg::CTRL_SELF_CLOCK_MODE_ENABLE] && en_reg[pllrt_pkg::EV_SCM]
		|=> !stop_active && self_clock_active && irq;
	endproperty
	a_scm_wake: assert property (p_scm_wake)
		else $error("self-clock wake failed");

	property p_scm_sleep;
		@(posedge clk_sys) disable iff (rst || mfr_reg)
		stop_active && lost_rise && ctrl_reg[pllrt_pkg::CTRL_CME]
		&& ctrl_reg[pllrt_pkg::CTRL_SELF_CLOCK_MODE_ENABLE] && !en_reg[pllrt_pkg::EV_SCM]
		&& !wake_other |=> stop_active && flag_reg[pllrt_pkg::EV_SCM];
	endproperty
	a_scm_sleep: assert property (p_scm_sleep)
		else $error("self-clock flag or stop wrong");

	property p_wake;
		@(posedge clk_sys) disable iff (rst || mfr_reg)
		stop_active && wake_other && !lost_rise |=> !stop_active;
	endproperty
	a_wake: assert property (p_wake)
		else $error("enabled interrupt did not wake");

	property p_exit_sel;
		@(posedge clk_sys) disable iff (rst)
		$fell(stop_active) |-> !system_clock_from_synth;
	endproperty
	a_exit_sel: assert property (p_exit_sel)
		else $error("synth select kept after stop");

	c_tick_wake: cover property (@(posedge clk_sys) disable iff (rst)
		stop_active && tick_pulse ##[1:2] !stop_active);
	c_mon: cover property (@(posedge clk_sys) disable iff (rst)
		monitor_fail_reset);
	c_scm: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(self_clock_active));
	c_lock: cover property (@(posedge clk_sys) disable iff (rst)
		$rose(settled_reg) && ctrl_reg[pllrt_pkg::CTRL_AUTO]);

endmodule : pllrt_ctrl

/* tb/tb_pllrt_ctrl.sv */
// self-checking testbench for the clock, tick and pseudo-stop control block
`timescale 1ns/1ns
module tb_pllrt_ctrl;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic       clk_sys         = 1'b0;
	logic       rst             = 1'b1;
	logic [2:0] reg_addr        = 3'h0;
	logic [7:0] reg_wdata       = 8'h00;
	logic       reg_wr          = 1'b0;
	logic       reg_rd          = 1'b0;
	logic [7:0] reg_rdata;
	logic       in_lock_tol     = 1'b0;
	logic       out_unlock_tol  = 1'b0;
	logic       in_track_tol    = 1'b0;
	logic       out_untrack_tol = 1'b0;
	logic       crystal_lost    = 1'b0;
	logic       synth_power_enable;
	logic       system_clock_from_synth;
	logic       filter_acquire;
	logic       self_clock_active;
	logic       stop_active;
	logic       monitor_fail_reset;
	logic       reset_from_monitor;
	logic       irq;
	int         err_count       = 0;
	int         n_tests         = 0;
	int         cyc             = 0;

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	pllrt_ctrl uut (
		.clk_sys                 (clk_sys),
		.rst                     (rst),
		.reg_addr                (reg_addr),
		.reg_wdata               (reg_wdata),
		.reg_wr                  (reg_wr),
		.reg_rd                  (reg_rd),
		.reg_rdata               (reg_rdata),
		.in_lock_tol             (in_lock_tol),
		.out_unlock_tol          (out_unlock_tol),
		.in_track_tol            (in_track_tol),
		.out_untrack_tol         (out_untrack_tol),
		.crystal_lost            (crystal_lost),
		.synth_power_enable      (synth_power_enable),
		.system_clock_from_synth (system_clock_from_synth),
		.filter_acquire          (filter_acquire),
		.self_clock_active       (self_clock_active),
		.stop_active             (stop_active),
		.monitor_fail_reset      (monitor_fail_reset),
		.reset_from_monitor      (reset_from_monitor),
		.irq                     (irq)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_cyc

	// extra idle edge so the written value has landed before any check
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys) begin
			reg_wr    <= 1'b1;
			reg_addr  <= a;
			reg_wdata <= d;
		end
		@(posedge clk_sys) reg_wr <= 1'b0;
		wait_cyc(1);
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk_sys) begin
			reg_rd   <= 1'b1;
			reg_addr <= a;
		end
		@(posedge clk_sys) reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd_chk

	function automatic logic cond(input int sel);
		case (sel)
			0:       return irq === 1'b1;
			1:       return stop_active === 1'b0;
			default: return monitor_fail_reset === 1'b1;
		endcase
	endfunction : cond

	task automatic wait_for(input int sel, input int lim);
		int i;
		i = 0;
		while (!cond(sel) && i < lim) begin
			wait_cyc(1);
			i++;
		end
		n_tests++;
		if (!cond(sel)) begin
			err_count++;
			$display("[FAIL] %0t wait %0d timed out", $time, sel);
		end
	endtask : wait_for

	task automatic do_reset();
		@(posedge clk_sys) begin
			rst             <= 1'b1;
			in_lock_tol     <= 1'b0;
			out_unlock_tol  <= 1'b0;
			in_track_tol    <= 1'b0;
			out_untrack_tol <= 1'b0;
			crystal_lost    <= 1'b0;
		end
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		wait_cyc(1);
	endtask : do_reset

	// period taken between two flag events, clearing in between
	task automatic measure(input logic [7:0] rate, input int exp);
		int c1;
		wr_reg(pllrt_pkg::ADDR_RATE, rate);
		wr_reg(pllrt_pkg::ADDR_CLEAR, 8'h01);
		wait_for(0, 70000);
		c1 = cyc;
		wr_reg(pllrt_pkg::ADDR_CLEAR, 8'h01);
		wait_for(0, 70000);
		chk(cyc - c1, exp);
	endtask : measure

	// ----------------------------------------------------------------
	// watchdog: whole sequence needs about 14500 cycles
	// ----------------------------------------------------------------
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_count++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		// reset values, refused and unmapped places
		rd_chk(pllrt_pkg::ADDR_RATE, 8'h00);
		rd_chk(pllrt_pkg::ADDR_CTRL, 8'h03);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h00);
		rd_chk(pllrt_pkg::ADDR_ENABLE, 8'h00);
		rd_chk(pllrt_pkg::ADDR_CLEAR, 8'h00);
		rd_chk(3'h7, 8'h00);
		chk(filter_acquire, 1'b1);

		// automatic bandwidth, detectors drive the flags
		wr_reg(pllrt_pkg::ADDR_ENABLE, 8'h02);
		@(posedge clk_sys) in_lock_tol <= 1'b1;
		wait_cyc(6);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h22);
		chk(irq, 1'b1);
		// synth clock picked only once the settled flag is seen set
		wr_reg(pllrt_pkg::ADDR_CTRL, 8'h0d);
		chk(system_clock_from_synth, 1'b1);
		@(posedge clk_sys) in_track_tol <= 1'b1;
		wait_cyc(6);
		chk(filter_acquire, 1'b0);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h32);
		wr_reg(pllrt_pkg::ADDR_CLEAR, 8'h02);
		wr_reg(pllrt_pkg::ADDR_FLAGS, 8'h00);
		@(posedge clk_sys) begin
			in_lock_tol     <= 1'b0;
			in_track_tol    <= 1'b0;
			out_untrack_tol <= 1'b1;
		end
		wait_cyc(6);
		chk(filter_acquire, 1'b1);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h20);
		chk(irq, 1'b0);
		@(posedge clk_sys) out_unlock_tol <= 1'b1;
		wait_cyc(6);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h02);
		chk(irq, 1'b1);

		// manual bandwidth, software keeps the waits
		do_reset();
		wr_reg(pllrt_pkg::ADDR_CTRL, 8'h06);
		chk(synth_power_enable, 1'b1);
		chk(filter_acquire, 1'b1);
		wait_cyc(20);
		wr_reg(pllrt_pkg::ADDR_CTRL, 8'h04);
		chk(filter_acquire, 1'b0);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h10);
		wait_cyc(20);
		wr_reg(pllrt_pkg::ADDR_CTRL, 8'h0c);
		chk(system_clock_from_synth, 1'b1);

		// pseudo-stop left by the tick, synth select dropped
		wr_reg(pllrt_pkg::ADDR_ENABLE, 8'h01);
		wr_reg(pllrt_pkg::ADDR_RATE, 8'h10);
		wr_reg(pllrt_pkg::ADDR_STOP, 8'h01);
		chk(stop_active, 1'b1);
		wait_for(1, 1200);
		chk(system_clock_from_synth, 1'b0);
		rd_chk(pllrt_pkg::ADDR_CTRL, 8'h04);
		chk(irq, 1'b1);

		// tick periods and tick off
		measure(8'h10, 1 << 10);
		measure(8'h21, 2 << 11);
		wr_reg(pllrt_pkg::ADDR_RATE, 8'h00);
		wr_reg(pllrt_pkg::ADDR_CLEAR, 8'h01);
		wait_cyc(3000);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h10);

		// clock loss, monitor on, self-clock off
		do_reset();
		wr_reg(pllrt_pkg::ADDR_CTRL, 8'h13);
		wr_reg(pllrt_pkg::ADDR_STOP, 8'h01);
		@(posedge clk_sys) crystal_lost <= 1'b1;
		wait_for(2, 12);
		wait_cyc(2);
		chk(reset_from_monitor, 1'b1);
		chk(stop_active, 1'b0);
		rd_chk(pllrt_pkg::ADDR_CTRL, 8'h03);

		// clock loss, self-clock on, its interrupt blocked
		do_reset();
		chk(reset_from_monitor, 1'b0);
		wr_reg(pllrt_pkg::ADDR_CTRL, 8'h33);
		wr_reg(pllrt_pkg::ADDR_STOP, 8'h01);
		@(posedge clk_sys) crystal_lost <= 1'b1;
		wait_cyc(8);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h84);
		chk(self_clock_active, 1'b0);

		// external reset while still stopped
		do_reset();
		chk(stop_active, 1'b0);
		rd_chk(pllrt_pkg::ADDR_CTRL, 8'h03);

		// clock loss, self-clock interrupt enabled, wakes up
		wr_reg(pllrt_pkg::ADDR_CTRL, 8'h33);
		wr_reg(pllrt_pkg::ADDR_ENABLE, 8'h04);
		wr_reg(pllrt_pkg::ADDR_STOP, 8'h01);
		@(posedge clk_sys) crystal_lost <= 1'b1;
		wait_cyc(8);
		chk(self_clock_active, 1'b1);
		chk(stop_active, 1'b0);
		chk(irq, 1'b1);

		// monitor off: loss ignored, settled change wakes instead
		do_reset();
		wr_reg(pllrt_pkg::ADDR_ENABLE, 8'h02);
		wr_reg(pllrt_pkg::ADDR_STOP, 8'h01);
		@(posedge clk_sys) crystal_lost <= 1'b1;
		wait_cyc(8);
		chk(stop_active, 1'b1);
		chk(reset_from_monitor, 1'b0);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h80);
		@(posedge clk_sys) in_lock_tol <= 1'b1;
		wait_cyc(6);
		chk(stop_active, 1'b0);
		chk(irq, 1'b1);
		rd_chk(pllrt_pkg::ADDR_FLAGS, 8'h22);
		end_sim();
	end

endmodule : tb_pllrt_ctrl
